// file: rtl/gpio_port.sv
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module gpio_port (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Avalon-MM slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Pins
    input  wire logic [7:0]  i_pin,
    output logic      [7:0]  o_pin,
    output logic      [7:0]  o_pin_oe,
    output logic      [7:0]  o_pullup_en,
    // Alternate function overrides
    input  wire logic [7:0]  i_alt_en,
    input  wire logic [7:0]  i_alt_oe,
    input  wire logic [7:0]  i_alt_out,
    // Sleep controller and external interrupt enables
    input  wire logic        i_deep_sleep,
    input  wire logic [7:0]  i_ext_int_en
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]                dir_r;
    logic [7:0]                dir_nxt;
    logic [7:0]                latch_r;
    logic [7:0]                latch_nxt;
    logic                      pud_r;
    logic                      pud_nxt;
    logic                      sw_sleep_r;
    logic                      sw_sleep_nxt;
    logic [31:0]               rdata_r;
    logic [31:0]               rdata_nxt;
    gpio_port_pkg::bus_state_t bus_r;
    gpio_port_pkg::bus_state_t bus_nxt;

    wire  [7:0]                pin_clamped;
    wire  [7:0]                pin_sync;
    wire                       sleep_any;

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    wire req;
    wire ack;
    wire wr_go;

    // One wait cycle for every access keeps read data registered
    assign req               = i_avs_read | i_avs_write;
    assign ack               = req & (bus_r == gpio_port_pkg::BUS_ACK);
    assign wr_go             = ack & i_avs_write;
    assign o_avs_waitrequest = req & ~ack;

    // Sequencer: idle until a request, then one answer cycle
    always_comb begin
        case (bus_r)
            gpio_port_pkg::BUS_IDLE: begin
                bus_nxt = req ? gpio_port_pkg::BUS_ACK : gpio_port_pkg::BUS_IDLE;
            end
            gpio_port_pkg::BUS_ACK: begin
                bus_nxt = gpio_port_pkg::BUS_IDLE;
            end
            default: begin
                bus_nxt = gpio_port_pkg::BUS_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire sel_latch;
    wire sel_dir;
    wire sel_input;
    wire sel_ctrl;
    wire sel_bitop;
    wire be0;

    assign sel_latch = (i_avs_address == gpio_port_pkg::OFS_LATCH);
    assign sel_dir   = (i_avs_address == gpio_port_pkg::OFS_DIR);
    assign sel_input = (i_avs_address == gpio_port_pkg::OFS_INPUT);
    assign sel_ctrl  = (i_avs_address == gpio_port_pkg::OFS_CTRL);
    assign sel_bitop = (i_avs_address == gpio_port_pkg::OFS_BITOP);
    // Port data sits in byte lane 0, except the bit-operation value at bit 8
    assign be0       = i_avs_byteenable[0];

    // ----------------------------------------------------------------
    // Whole-register writes
    // ----------------------------------------------------------------
    wire       wr_latch;
    wire       wr_dir;
    wire       wr_toggle;
    wire       wr_ctrl;
    wire [7:0] wdata8;

    assign wdata8    = i_avs_writedata[7:0];
    assign wr_latch  = wr_go & be0 & sel_latch;
    assign wr_dir    = wr_go & be0 & sel_dir;
    assign wr_toggle = wr_go & be0 & sel_input;
    assign wr_ctrl   = wr_go & be0 & sel_ctrl;

    // ----------------------------------------------------------------
    // Single-bit operation decode
    // ----------------------------------------------------------------
    wire                               wr_bitop;
    wire [gpio_port_pkg::BITOP_IDX_W-1:0] bit_idx;
    wire [1:0]                         bit_tgt;
    wire                               bit_val;
    wire [7:0]                         bit_mask;
    wire                               bit_latch;
    wire                               bit_dir;
    wire                               bit_input;

    assign wr_bitop  = wr_go & be0 & sel_bitop;
    assign bit_idx   = i_avs_writedata[gpio_port_pkg::BITOP_IDX_LSB +:
                                       gpio_port_pkg::BITOP_IDX_W];
    assign bit_tgt   = i_avs_writedata[gpio_port_pkg::BITOP_TGT_LSB +: 2];
    assign bit_val   = i_avs_writedata[gpio_port_pkg::BITOP_VAL_BIT];
    // Mask holds exactly one bit so the neighbours stay put
    assign bit_mask  = 8'h01 << bit_idx;
    assign bit_latch = wr_bitop & (bit_tgt == gpio_port_pkg::TGT_LATCH);
    assign bit_dir   = wr_bitop & (bit_tgt == gpio_port_pkg::TGT_DIR);
    // Clearing an input bit is a no-op, setting one toggles
    assign bit_input = wr_bitop & (bit_tgt == gpio_port_pkg::TGT_INPUT) & bit_val;

    // ----------------------------------------------------------------
    // Next-value logic for direction and latch
    // ----------------------------------------------------------------
    wire [7:0] dir_bitop;
    wire [7:0] latch_bitop;
    wire [7:0] toggle_mask;

    assign dir_bitop   = bit_val ? (dir_r | bit_mask) : (dir_r & ~bit_mask);
    assign latch_bitop = bit_val ? (latch_r | bit_mask) : (latch_r & ~bit_mask);
    // Toggle ignores direction entirely
    assign toggle_mask = (wr_toggle ? wdata8 : 8'h00) |
                         (bit_input ? bit_mask : 8'h00);

    always_comb begin
        dir_nxt = dir_r;
        if (wr_dir) begin
            dir_nxt = wdata8;
        end else if (bit_dir) begin
            dir_nxt = dir_bitop;
        end
    end

    always_comb begin
        latch_nxt = latch_r ^ toggle_mask;
        if (wr_latch) begin
            latch_nxt = wdata8;
        end else if (bit_latch) begin
            latch_nxt = latch_bitop;
        end
    end

    // Global control: pull-up disable and a software sleep request
    always_comb begin
        pud_nxt      = pud_r;
        sw_sleep_nxt = sw_sleep_r;
        if (wr_ctrl) begin
            pud_nxt      = i_avs_writedata[gpio_port_pkg::CTRL_PUD_BIT];
            sw_sleep_nxt = i_avs_writedata[gpio_port_pkg::CTRL_SLEEP_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    wire [7:0] rd_port;
    wire [1:0] rd_ctrl;

    assign rd_ctrl = {sw_sleep_r, pud_r};
    assign rd_port = sel_latch ? latch_r :
                     sel_dir   ? dir_r :
                     sel_input ? pin_sync :
                     sel_ctrl  ? {6'h00, rd_ctrl} :
                     8'h00;

    // Captured on the wait cycle, shown on the answer cycle
    always_comb begin
        rdata_nxt = rdata_r;
        if (i_avs_read & ~ack) begin
            rdata_nxt = {24'h000000, rd_port};
        end
    end

    assign o_avs_readdata = rdata_r;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Asynchronous clear tri-states pins not under alternate override even with the clock stopped
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dir_r   <= gpio_port_pkg::RST_PORT;
            latch_r <= gpio_port_pkg::RST_PORT;
        end else begin
            dir_r   <= dir_nxt;
            latch_r <= latch_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pud_r      <= gpio_port_pkg::RST_CTRL[gpio_port_pkg::CTRL_PUD_BIT];
            sw_sleep_r <= gpio_port_pkg::RST_CTRL[gpio_port_pkg::CTRL_SLEEP_BIT];
        end else begin
            pud_r      <= pud_nxt;
            sw_sleep_r <= sw_sleep_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_r   <= gpio_port_pkg::BUS_IDLE;
            rdata_r <= 32'h00000000;
        end else begin
            bus_r   <= bus_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Per-pin control
    // ----------------------------------------------------------------
    assign sleep_any = i_deep_sleep | sw_sleep_r;

    // Each pin decodes alone, so overrides never leak sideways
    genvar g;
    generate
        for (g = 0; g < gpio_port_pkg::PIN_COUNT; g = g + 1) begin : g_pin
            gpio_pin_ctrl u_pin (
                .i_dir         (dir_r[g]),
                .i_latch       (latch_r[g]),
                .i_pud         (pud_r),
                .i_alt_en      (i_alt_en[g]),
                .i_alt_oe      (i_alt_oe[g]),
                .i_alt_out     (i_alt_out[g]),
                .i_sleep       (sleep_any),
                .i_ext_int_en  (i_ext_int_en[g]),
                .i_pin_raw     (i_pin[g]),
                .o_pin_out     (o_pin[g]),
                .o_pin_oe      (o_pin_oe[g]),
                .o_pullup      (o_pullup_en[g]),
                .o_pin_clamped (pin_clamped[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Input synchroniser
    // ----------------------------------------------------------------
    // Adds one to two cycles of delay; read back after a write lags
    gpio_input_sync u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (pin_clamped),
        .o_sync  (pin_sync)
    );

endmodule
`default_nettype wire

// file: rtl/gpio_port_pkg.sv
package gpio_port_pkg;

    // ----------------------------------------------------------------
    // Port geometry
    // ----------------------------------------------------------------
    localparam int unsigned PIN_COUNT   = 8;
    localparam int unsigned ADDR_W      = 5;
    localparam int unsigned DATA_W      = 32;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0]  OFS_LATCH   = 5'h00;
    localparam logic [4:0]  OFS_DIR     = 5'h04;
    localparam logic [4:0]  OFS_INPUT   = 5'h08;
    localparam logic [4:0]  OFS_CTRL    = 5'h0C;
    localparam logic [4:0]  OFS_BITOP   = 5'h10;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_PUD_BIT   = 0;
    localparam int unsigned CTRL_SLEEP_BIT = 1;

    // ----------------------------------------------------------------
    // Bit operation register fields
    // ----------------------------------------------------------------
    localparam int unsigned BITOP_IDX_LSB  = 0;
    localparam int unsigned BITOP_IDX_W    = 3;
    localparam int unsigned BITOP_TGT_LSB  = 4;
    localparam int unsigned BITOP_VAL_BIT  = 8;
    localparam logic [1:0]  TGT_LATCH      = 2'h0;
    localparam logic [1:0]  TGT_DIR        = 2'h1;
    localparam logic [1:0]  TGT_INPUT      = 2'h2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_PORT       = 8'h00;
    localparam logic [1:0]  RST_CTRL       = 2'h0;

    // ----------------------------------------------------------------
    // Bus answer sequencing
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_t;

endpackage

// file: rtl/gpio_input_sync.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_input_sync (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_async,
    output logic      [7:0] o_sync
);

    // ----------------------------------------------------------------
    // Two-stage synchroniser
    // ----------------------------------------------------------------
    logic [7:0] meta_r;
    logic [7:0] sync_r;

    // First stage feeds only the second; pin level may be metastable
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= gpio_port_pkg::RST_PORT;
            sync_r <= gpio_port_pkg::RST_PORT;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule
`default_nettype wire

// file: rtl/gpio_pin_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_ctrl (
    input  wire logic i_dir,
    input  wire logic i_latch,
    input  wire logic i_pud,
    input  wire logic i_alt_en,
    input  wire logic i_alt_oe,
    input  wire logic i_alt_out,
    input  wire logic i_sleep,
    input  wire logic i_ext_int_en,
    input  wire logic i_pin_raw,
    output logic      o_pin_out,
    output logic      o_pin_oe,
    output logic      o_pullup,
    output logic      o_pin_clamped
);

    // ----------------------------------------------------------------
    // Per-pin drive and pull-up decode
    // ----------------------------------------------------------------
    wire gp_oe;
    wire gp_pull;
    wire clamp;

    // Alternate override acts on this pin alone
    assign gp_oe         = i_dir;
    assign gp_pull       = ~i_dir & i_latch & ~i_pud;
    assign o_pin_oe      = i_alt_en ? i_alt_oe : gp_oe;
    assign o_pin_out     = i_alt_en ? i_alt_out : i_latch;
    assign o_pullup      = ~i_alt_en & gp_pull;
    // Clamp stops floating inputs burning current in deep sleep
    assign clamp         = i_sleep & ~i_ext_int_en & ~i_alt_en;
    assign o_pin_clamped = i_pin_raw & ~clamp;

endmodule
`default_nettype wire

// file: dv/gpio_port_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_port_asserts (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire logic        o_avs_waitrequest,
    input  wire logic [7:0]  o_pin,
    input  wire logic [7:0]  o_pin_oe,
    input  wire logic [7:0]  o_pullup_en,
    input  wire logic [7:0]  i_alt_en,
    input  wire logic [7:0]  i_alt_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // ----------------------------------------------------------------
    // Accepted write decode
    // ----------------------------------------------------------------
    // Lane 0 carries port data except the bit-operation value at bit 8; other lane enables never count
    wire logic       wr_acc = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
    wire logic [7:0] wd     = i_avs_writedata[7:0];
    wire logic [2:0] idx    = i_avs_writedata[2:0];
    wire logic       no_alt = (i_alt_en == 8'h00);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_dir_drives_oe: assert property (wr_acc && i_avs_address == gpio_port_pkg::OFS_DIR &&
        no_alt |=> o_pin_oe == $past(wd)) else $error("drive enable not from direction");
    a_latch_drives_pin: assert property (wr_acc && no_alt &&
        i_avs_address == gpio_port_pkg::OFS_LATCH |=> o_pin == $past(wd))
        else $error("pin level not from latch");
    a_pullup_gated: assert property (no_alt |-> (o_pullup_en & (o_pin_oe | ~o_pin)) == 8'h00)
        else $error("pull-up on for output or zero latch");
    a_reset_tristate: assert property (disable iff (1'b0) i_rst |->
        o_pin_oe == 8'h00 && o_pullup_en == 8'h00) else $error("pins driven in reset");
    a_toggle_latch: assert property (wr_acc && i_avs_address == gpio_port_pkg::OFS_INPUT &&
        no_alt |=> o_pin == ($past(o_pin) ^ $past(wd))) else $error("toggle wrong");
    a_answer_wait: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest |=>
        !o_avs_waitrequest) else $error("answer not one cycle later");
    a_global_pud: assert property (wr_acc && i_avs_address == gpio_port_pkg::OFS_CTRL &&
        wd[0] |=> o_pullup_en == 8'h00) else $error("pull-up on under global disable");
    a_bitop_one_bit: assert property (wr_acc && i_avs_address == gpio_port_pkg::OFS_BITOP &&
        i_avs_writedata[5:4] == gpio_port_pkg::TGT_DIR && no_alt |=>
        ((o_pin_oe ^ $past(o_pin_oe)) & ~(8'h01 << $past(idx))) == 8'h00)
        else $error("bit operation touched other pins");
    a_alt_owns_oe: assert property (((o_pin_oe ^ i_alt_oe) & i_alt_en) == 8'h00)
        else $error("alternate drive enable ignored");
    a_reset_clears: assert property ($fell(i_rst) |-> o_pin_oe == 8'h00 && o_pin == 8'h00)
        else $error("state not cleared by reset");

    // Main scenarios reached
    c_toggle: cover property (wr_acc && i_avs_address == gpio_port_pkg::OFS_INPUT);
    c_bitop: cover property (wr_acc && i_avs_address == gpio_port_pkg::OFS_BITOP);
    c_read: cover property (i_avs_read && !o_avs_waitrequest);
endmodule

bind gpio_port gpio_port_asserts u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_waitrequest(o_avs_waitrequest), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .o_pullup_en(o_pullup_en), .i_alt_en(i_alt_en), .i_alt_oe(i_alt_oe));
`default_nettype wire

// file: dv/gpio_pin_world.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_world (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pullup,
    input  wire logic [7:0] i_ext_en,
    input  wire logic [7:0] i_ext_val,
    output logic      [7:0] o_level
);
    logic [7:0] float_r = 8'h55;

    // Floating pins wander every cycle, so a stale level never reads as valid
    always @(posedge i_clk) begin
        float_r <= ~float_r;
    end

    // Port drive wins, then outside drive, then pull-up, else floating
    assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
                   | (~i_oe & ~i_ext_en & (i_pullup | float_r));
endmodule
`default_nettype wire

// file: dv/tb_gpio_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_gpio_port;
    localparam logic [4:0] LAT = gpio_port_pkg::OFS_LATCH;
    localparam logic [4:0] DIR = gpio_port_pkg::OFS_DIR;
    localparam logic [4:0] INP = gpio_port_pkg::OFS_INPUT;
    localparam logic [4:0] CTL = gpio_port_pkg::OFS_CTRL;
    localparam logic [4:0] BOP = gpio_port_pkg::OFS_BITOP;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [4:0]  adr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [3:0]  be = 4'hF;
    logic [7:0]  alt_en = 8'h00;
    logic [7:0]  alt_oe = 8'h00;
    logic        sleep = 1'b0;
    logic [7:0]  int_en = 8'h00;
    logic [7:0]  ext_en = 8'hFF;
    logic [7:0]  ext_val = 8'h00;
    logic [31:0] rdata;
    logic        wreq;
    logic [7:0]  lvl;
    logic [7:0]  pout;
    logic [7:0]  poe;
    logic [7:0]  pup;
    int          failures = 0;
    int          samples_checked = 0;
    // Bit operations: word, expected latch, expected direction
    logic [8:0]  op [6] = '{9'h117, 9'h001, 9'h120, 9'h020, 9'h132, 9'h013};
    logic [7:0]  xl [6] = '{8'h5A, 8'h58, 8'h59, 8'h59, 8'h59, 8'h59};
    logic [7:0]  xd [6] = '{8'h8F, 8'h8F, 8'h8F, 8'h8F, 8'h8F, 8'h87};

    always #5 i_clk = ~i_clk;

    gpio_port u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_pin(lvl),
        .o_pin(pout), .o_pin_oe(poe), .o_pullup_en(pup), .i_alt_en(alt_en),
        .i_alt_oe(alt_oe), .i_alt_out(8'h00), .i_deep_sleep(sleep),
        .i_ext_int_en(int_en));

    gpio_pin_world u_world (
        .i_clk(i_clk), .i_out(pout), .i_oe(poe), .i_pullup(pup),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(lvl));

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    // Request held until waitrequest is seen low; no latency assumed
    task automatic bus(input logic w, input logic [4:0] a, input logic [8:0] d);
        @(posedge i_clk);
        adr <= a;
        wd <= {23'h000000, d};
        wr <= w;
        rd <= ~w;
        @(posedge i_clk);
        while (wreq !== 1'b0) @(posedge i_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge i_clk);
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 9'h000);
        chk("readdata", e, rdata[7:0]);
    endtask

    task automatic report_and_stop;
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge i_clk);
        chk("oe", 8'h00, poe);
        chk("pullup", 8'h00, pup);
        i_rst <= 1'b0;
        rchk(LAT, 8'h00);
        rchk(DIR, 8'h00);
        rchk(INP, 8'h00);
        bus(1'b1, LAT, 9'h0A5);
        bus(1'b1, DIR, 9'h00F);
        chk("oe", 8'h0F, poe);
        chk("pin", 8'h05, pout & poe);
        chk("pullup", 8'hA0, pup);
        @(posedge i_clk);
        ext_en <= 8'h50;
        ext_val <= 8'h40;
        repeat (3) @(posedge i_clk);
        rchk(INP, 8'hE5);
        rchk(LAT, 8'hA5);
        rchk(DIR, 8'h0F);
        rchk(5'h14, 8'h00);
        bus(1'b1, INP, 9'h0FF);
        rchk(LAT, 8'h5A);
        chk("pullup", 8'h50, pup);
        @(posedge i_clk);
        be <= 4'hE;
        bus(1'b1, LAT, 9'h0FF);
        be <= 4'hF;
        rchk(LAT, 8'h5A);
        bus(1'b1, CTL, 9'h001);
        chk("pullup", 8'h00, pup);
        bus(1'b1, CTL, 9'h000);
        chk("pullup", 8'h50, pup);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, BOP, op[i]);
            chk("latch", xl[i], pout);
            chk("dir", xd[i], poe);
        end
        chk("pullup", 8'h58, pup);
        // Alternate owner on pin 0 drives low; pin 7 held high outside
        bus(1'b1, DIR, 9'h07E);
        bus(1'b1, LAT, 9'h07F);
        @(posedge i_clk);
        alt_en <= 8'h01;
        alt_oe <= 8'h01;
        ext_en <= 8'hFF;
        ext_val <= 8'h80;
        int_en <= 8'h80;
        @(negedge i_clk);
        chk("oe", 8'h7F, poe);
        chk("pin", 8'h7E, pout & 8'hFE);
        // New pin levels need two edges through the synchroniser
        repeat (2) @(posedge i_clk);
        rchk(INP, 8'hFE);
        @(posedge i_clk);
        sleep <= 1'b1;
        repeat (3) @(posedge i_clk);
        rchk(INP, 8'h80);
        // Reset between edges must tri-state at once
        @(posedge i_clk);
        alt_en <= 8'h00;
        i_rst <= 1'b1;
        #1;
        chk("oe", 8'h00, poe);
        chk("pullup", 8'h00, pup);
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rchk(DIR, 8'h00);
        report_and_stop();
    end

    // Whole sequence needs about a hundred cycles
    initial begin
        repeat (3000) @(posedge i_clk);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
